// File: rcst_streamer.sv
// Function
// - Claim only register cycles in own window.
// - Ring control write starts the fetch engine.
// - Fetch address is ring start plus head.
// - Exactly one cache_line per read request.
// - Eight-line FIFO, slot reserved before each read.
// - Fetch keeps private head and tail copies.
// - Private head advances after every ring fetch request.
// - Stop fetching when private head reaches tail.
// - Parser starts as soon as FIFO holds data.
// - Header decode routes to 3D, compute, local.
// - Forwarded commands lose their header dword.
// - Architectural head moves only on command completion, head register write or context load.
// - Ring empty when head equals tail.
// - Pipeline type, opcode, sub-opcode select command.
// - Separate fetch path for execution lists.
// - Interrupt on context switch and user request.
// - Flush both engines; no-ops have no effect.
// - No coupling to the video_codec_engine streamer.
// - Pipeline select chooses 3D or compute mode.
// - List elements run one after another.
`timescale 1ns/100ps
`include "rcst_defs.svh"

module rcst_streamer (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire rcst_pkg::rcst_mmio_t mmio_i,
	output logic mmio_ack_o,
	output logic [31:0] mmio_rdata_o,
	output rcst_pkg::rcst_memreq_t mem_req_o,
	input wire logic mem_req_ready_i,
	input wire logic mem_rsp_valid_i,
	input wire logic [`RCST_LINE_BITS-1:0] mem_rsp_data_i,
	output rcst_pkg::rcst_cmd_t cmd_o,
	input wire logic cmd_ready_i,
	output logic pipe_mode_o,
	output logic ring_empty_o,
	output logic user_irq_o,
	output logic ctx_irq_o,
	output logic flush_3d_o,
	output logic flush_cmp_o
);

	// ==========================================================
	// Helpers

	// Adds to a ring offset and folds it back past the ring end.
	function automatic logic [31:0] wrap_add(input logic [31:0] ofs,
		input logic [31:0] inc, input logic [8:0] pg);
		logic [31:0] lim;
		logic [31:0] sum;
		lim = ({23'h0, pg} + 32'h1) << 12;
		sum = ofs + inc;
		wrap_add = (sum >= lim) ? sum - lim : sum;
	endfunction : wrap_add

	// Switches the ring to a new context, emptying the FIFO.
	function automatic rcst_pkg::rcst_state_t load_ctx(
		input rcst_pkg::rcst_state_t st, input logic [31:0] base,
		input logic [31:0] tl);
		load_ctx = st;
		load_ctx.start = base;
		load_ctx.tail = tl;
		load_ctx.ftail = tl;
		load_ctx.head = 32'h0;
		load_ctx.fhead = 32'h0;
		load_ctx.pcur = 32'h0;
		load_ctx.dw_idx = 4'h0;
		load_ctx.wr_ptr = 3'h0;
		load_ctx.rd_ptr = 3'h0;
		load_ctx.count = 5'h0;
		load_ctx.en = 1'b1;
		load_ctx.pst = rcst_pkg::P_HDR;
	endfunction : load_ctx

	// ==========================================================
	// Declarations
	rcst_pkg::rcst_state_t s_r;
	rcst_pkg::rcst_state_t s_nxt;
	logic [31:0] dw;
	logic in_win;
	logic idle;
	logic issue_el;
	logic issue_ring;
	logic take;
	logic ld_ctx;
	logic done;
	logic head_wr;
	logic [9:0] done_len;

	// ==========================================================
	// Fetch and parse conditions

	// Only addresses inside the window are claimed at all.
	assign in_win = mmio_i.valid && mmio_i.addr >= `RCST_WIN_LO &&
		mmio_i.addr <= `RCST_WIN_HI;
	assign dw = s_r.fifo[s_r.rd_ptr][{s_r.dw_idx, 5'h0} +: 32];
	assign idle = s_r.outst == 5'h0 && s_r.count == 5'h0 &&
		s_r.head == s_r.tail && s_r.pst == rcst_pkg::P_HDR &&
		!s_r.out.valid;
	// The list fetch waits for a drained ring so elements never overlap.
	assign issue_el = clk_en_i && s_r.el_pend && !s_r.el_wait && idle;
	// A read is only issued while a FIFO slot is free for its data.
	assign issue_ring = clk_en_i && s_r.en && !s_r.el_pend &&
		!s_r.el_wait && s_r.fhead != s_r.ftail &&
		(s_r.count + s_r.outst < 5'd8);
	assign ld_ctx = clk_en_i && idle && s_r.el_has1 && !s_r.el_pend &&
		!s_r.el_wait;
	// Parsing starts on the first valid dword and stops at the tail.
	assign take = clk_en_i && s_r.en && s_r.count != 5'h0 &&
		s_r.pcur != s_r.tail &&
		(s_r.pst == rcst_pkg::P_SKIP || !s_r.out.valid ||
		(s_r.pst == rcst_pkg::P_FWD && cmd_ready_i));

	// ==========================================================
	// Outputs
	assign mem_req_o = '{valid: issue_el || issue_ring, el: issue_el,
		addr: issue_el ? s_r.el_addr : s_r.start + s_r.fhead};
	assign cmd_o = '{valid: s_r.out.valid && clk_en_i,
		last: s_r.out.last, dest: s_r.out.dest, data: s_r.out.data};
	assign mmio_ack_o = s_r.ack;
	assign mmio_rdata_o = s_r.rdata;
	assign pipe_mode_o = s_r.mode;
	assign ring_empty_o = s_r.head == s_r.tail;
	assign user_irq_o = s_r.irq_user;
	assign ctx_irq_o = s_r.irq_ctx;
	assign flush_3d_o = s_r.fl3d;
	assign flush_cmp_o = s_r.flcmp;

	// ==========================================================
	// Next state
	// Only the destination's ready stalls the parser; there is no
	// handshake with the video_codec_engine streamer at all.
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.irq_user = 1'b0;
		s_nxt.irq_ctx = 1'b0;
		s_nxt.fl3d = 1'b0;
		s_nxt.flcmp = 1'b0;
		done = 1'b0;
		head_wr = 1'b0;
		done_len = s_r.cmd_len;
		// The body's last dword leaving completes the command.
		if (cmd_o.valid && cmd_ready_i) begin
			s_nxt.out.valid = 1'b0;
			done = s_r.out.last;
		end
		// Each accepted ring read moves the private head one cache_line.
		if (mem_req_o.valid && mem_req_ready_i) begin
			if (issue_el) begin
				s_nxt.el_pend = 1'b0;
				s_nxt.el_wait = 1'b1;
			end else begin
				s_nxt.outst = s_nxt.outst + 5'h1;
				s_nxt.fhead = wrap_add(s_r.fhead, `RCST_LINE_BYTES,
					s_r.len_pg);
			end
		end
		// Returning lines fill the slot that was reserved for them.
		if (mem_rsp_valid_i) begin
			if (s_r.el_wait) begin
				s_nxt = load_ctx(s_nxt, mem_rsp_data_i[31:0],
					mem_rsp_data_i[63:32]);
				s_nxt.el_wait = 1'b0;
				s_nxt.el_start1 = mem_rsp_data_i[95:64];
				s_nxt.el_tail1 = mem_rsp_data_i[127:96];
				s_nxt.el_has1 = mem_rsp_data_i[127:96] != 32'h0;
			end else begin
				s_nxt.fifo[s_r.wr_ptr] = mem_rsp_data_i;
				s_nxt.wr_ptr = s_r.wr_ptr + 3'h1;
				s_nxt.count = s_nxt.count + 5'h1;
				s_nxt.outst = s_nxt.outst - 5'h1;
			end
		end
		// Parser consumes one dword per cycle.
		if (take) begin
			s_nxt.pcur = wrap_add(s_r.pcur, 32'h4, s_r.len_pg);
			s_nxt.dw_idx = s_r.dw_idx + 4'h1;
			if (s_r.dw_idx == 4'hf) begin
				s_nxt.rd_ptr = s_r.rd_ptr + 3'h1;
				s_nxt.count = s_nxt.count - 5'h1;
			end
			case (s_r.pst)
				rcst_pkg::P_HDR: begin
					if (dw[`RCST_F_CLIENT] == `RCST_CLI_GFX) begin
						s_nxt.cmd_len = {2'h0, dw[`RCST_F_LEN]} +
							`RCST_LEN_BIAS;
						s_nxt.rem = {1'b0, dw[`RCST_F_LEN]} + 9'h1;
						s_nxt.dest = dw[`RCST_F_PIPE] == `RCST_PIPE_CMP;
						// Header stays behind; only the body moves on.
						if (dw[`RCST_F_PIPE] == `RCST_PIPE_3D ||
							dw[`RCST_F_PIPE] == `RCST_PIPE_CMP) begin
							s_nxt.pst = rcst_pkg::P_FWD;
						end else begin
							s_nxt.pst = rcst_pkg::P_SKIP;
						end
						if (dw[`RCST_F_PIPE] == `RCST_PIPE_CTL &&
							dw[`RCST_F_OPC] == `RCST_SEL_OPC &&
							dw[`RCST_F_SUBOPC] == `RCST_SEL_SUBOPC) begin
							s_nxt.mode = dw[0];
						end
					end else begin
						// Local one-dword commands finish at once.
						done = 1'b1;
						done_len = 10'h1;
						if (dw[`RCST_F_CLIENT] == `RCST_CLI_MI) begin
							case (dw[`RCST_F_MIOPC])
								`RCST_MI_USER_INT: begin
									s_nxt.irq_user = 1'b1;
								end
								`RCST_MI_FLUSH: begin
									s_nxt.fl3d = 1'b1;
									s_nxt.flcmp = 1'b1;
								end
								default: begin
									s_nxt.irq_user = 1'b0;
								end
							endcase
						end
					end
				end
				rcst_pkg::P_FWD: begin
					s_nxt.out = '{valid: 1'b1, last: s_r.rem == 9'h1,
						dest: s_r.dest, data: dw};
					s_nxt.rem = s_r.rem - 9'h1;
					if (s_r.rem == 9'h1) begin
						s_nxt.pst = rcst_pkg::P_HDR;
					end
				end
				rcst_pkg::P_SKIP: begin
					s_nxt.rem = s_r.rem - 9'h1;
					if (s_r.rem == 9'h1) begin
						s_nxt.pst = rcst_pkg::P_HDR;
						done = 1'b1;
					end
				end
				default: begin
					s_nxt.pst = rcst_pkg::P_HDR;
				end
			endcase
		end
		// Head is architectural: it moves when a command has finished.
		if (done) begin
			s_nxt.head = wrap_add(s_r.head, {20'h0, done_len, 2'h0},
				s_r.len_pg);
		end
		// Register window; writes take effect, reads answer next cycle.
		if (clk_en_i && in_win) begin
			s_nxt.ack = 1'b1;
			s_nxt.rdata = 32'h0;
			case (mmio_i.addr)
				`RCST_TAIL_OFS: begin
					s_nxt.rdata = s_r.tail;
					if (mmio_i.wr) begin
						s_nxt.tail = mmio_i.wdata;
						s_nxt.ftail = mmio_i.wdata;
					end
				end
				`RCST_HEAD_OFS: begin
					s_nxt.rdata = s_r.head;
					if (mmio_i.wr) begin
						head_wr = 1'b1;
						s_nxt.head = mmio_i.wdata;
						s_nxt.pcur = mmio_i.wdata;
					end
				end
				`RCST_START_OFS: begin
					s_nxt.rdata = s_r.start;
					if (mmio_i.wr) begin
						s_nxt.start = mmio_i.wdata;
					end
				end
				`RCST_CTL_OFS: begin
					s_nxt.rdata = {11'h0, s_r.len_pg, 11'h0, s_r.en};
					if (mmio_i.wr) begin
						s_nxt.en = mmio_i.wdata[`RCST_CTL_EN];
						s_nxt.len_pg = mmio_i.wdata[`RCST_CTL_LEN];
						// Enabling kicks the fetch from the current head.
						if (mmio_i.wdata[`RCST_CTL_EN] && !s_r.en) begin
							s_nxt.fhead = {s_r.head[31:6], 6'h0};
							s_nxt.pcur = s_r.head;
							s_nxt.dw_idx = s_r.head[5:2];
							s_nxt.wr_ptr = 3'h0;
							s_nxt.rd_ptr = 3'h0;
							s_nxt.count = 5'h0;
							s_nxt.pst = rcst_pkg::P_HDR;
						end
					end
				end
				`RCST_ELSP_OFS: begin
					s_nxt.rdata = s_r.el_addr;
					if (mmio_i.wr) begin
						s_nxt.el_addr = mmio_i.wdata;
						s_nxt.el_pend = 1'b1;
					end
				end
				`RCST_STAT_OFS: begin
					s_nxt.rdata = {27'h0, s_r.el_has1, idle, s_r.mode,
						s_r.head == s_r.tail, s_r.en};
				end
				default: begin
					s_nxt.rdata = 32'h0;
				end
			endcase
		end
		// A drained ring hands over to the next list element.
		if (ld_ctx) begin
			s_nxt = load_ctx(s_nxt, s_r.el_start1, s_r.el_tail1);
			s_nxt.el_has1 = 1'b0;
			s_nxt.irq_ctx = 1'b1;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
			s_r.pst <= rcst_pkg::P_HDR;
		end else if (clk_en_i) begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_hdr_take;
		take && s_r.pst == rcst_pkg::P_HDR;
	endsequence

	sequence s_last_taken;
		cmd_o.valid && cmd_o.last && cmd_ready_i;
	endsequence

	a_window_only: assert property (
		(clk_en_i && mmio_i.valid && !in_win) |=> !mmio_ack_o)
		else $error("Ack given outside window.");
	a_kick_fetch: assert property (
		(clk_en_i && in_win && mmio_i.wr &&
		mmio_i.addr == `RCST_CTL_OFS &&
		mmio_i.wdata[0]) |=> s_r.en)
		else $error("Ring write did not start fetch.");
	a_addr_form: assert property (
		(mem_req_o.valid && !mem_req_o.el) |->
		mem_req_o.addr - s_r.start == s_r.fhead)
		else $error("Fetch address not start plus head.");
	a_line_only: assert property (
		(mem_req_o.valid && !mem_req_o.el) |->
		mem_req_o.addr[5:0] == 6'h0)
		else $error("Read not on a line boundary.");
	a_fifo_room: assert property (
		mem_req_o.valid |-> s_r.count + s_r.outst < 5'd8)
		else $error("Read issued without a free slot.");
	a_fhead_step: assert property (
		(mem_req_o.valid && !mem_req_o.el && mem_req_ready_i) |=>
		s_r.fhead == wrap_add($past(s_r.fhead), `RCST_LINE_BYTES,
		s_r.len_pg))
		else $error("Private head did not advance.");
	a_stop_tail: assert property (
		(s_r.fhead == s_r.ftail) |-> !issue_ring)
		else $error("Fetch beyond the tail.");
	a_strip_hdr: assert property (
		s_hdr_take |=> !cmd_o.valid)
		else $error("Header dword was forwarded.");
	a_head_hold: assert property (
		(clk_en_i && !done && !head_wr && !ld_ctx &&
		!(mem_rsp_valid_i && s_r.el_wait)) |=> $stable(s_r.head))
		else $error("Head moved without completion.");
	a_head_done: assert property (
		s_last_taken |=> s_r.head == wrap_add($past(s_r.head),
		{20'h0, $past(s_r.cmd_len), 2'h0}, s_r.len_pg))
		else $error("Head not advanced by command length.");
	a_empty_stop: assert property (
		(s_r.pcur == s_r.tail) |-> !take)
		else $error("Parsing an empty ring.");
	a_user_irq: assert property (
		(s_hdr_take ##0 (dw[`RCST_F_CLIENT] == `RCST_CLI_MI &&
		dw[`RCST_F_MIOPC] == `RCST_MI_USER_INT)) |=> user_irq_o)
		else $error("User interrupt missed.");

endmodule : rcst_streamer

// File: rcst_defs.svh
`ifndef RCST_DEFS_SVH
`define RCST_DEFS_SVH

// ==========================================================
// Register window and register offsets
`define RCST_WIN_LO 16'h2000
`define RCST_WIN_HI 16'h27ff
`define RCST_TAIL_OFS 16'h2030
`define RCST_HEAD_OFS 16'h2034
`define RCST_START_OFS 16'h2038
`define RCST_CTL_OFS 16'h203c
`define RCST_ELSP_OFS 16'h2230
`define RCST_STAT_OFS 16'h2240

// ==========================================================
// Control register fields
`define RCST_CTL_EN 0
`define RCST_CTL_LEN 20:12

// ==========================================================
// Command FIFO geometry
`define RCST_FIFO_LINES 8
`define RCST_LINE_DW 16
`define RCST_LINE_BITS 512
`define RCST_LINE_BYTES 32'h40

// ==========================================================
// Header fields and encodings
`define RCST_F_CLIENT 31:29
`define RCST_F_PIPE 28:27
`define RCST_F_OPC 26:24
`define RCST_F_SUBOPC 23:16
`define RCST_F_MIOPC 28:23
`define RCST_F_LEN 7:0
`define RCST_LEN_BIAS 10'h2
`define RCST_CLI_MI 3'h0
`define RCST_CLI_GFX 3'h3
`define RCST_PIPE_3D 2'h3
`define RCST_PIPE_CMP 2'h2
`define RCST_PIPE_CTL 2'h1
`define RCST_SEL_OPC 3'h1
`define RCST_SEL_SUBOPC 8'h04
`define RCST_MI_NOOP 6'h00
`define RCST_MI_USER_INT 6'h02
`define RCST_MI_FLUSH 6'h04

`endif

// File: rcst_pkg.sv
`include "rcst_defs.svh"

package rcst_pkg;

	// ==========================================================
	// Parser states
	typedef enum logic [2:0] {
		P_HDR = 3'b001,
		P_FWD = 3'b010,
		P_SKIP = 3'b100
	} rcst_pst_t;

	// ==========================================================
	// Port carriers
	typedef struct packed {
		logic valid;
		logic wr;
		logic [15:0] addr;
		logic [31:0] wdata;
	} rcst_mmio_t;

	typedef struct packed {
		logic valid;
		logic el;
		logic [31:0] addr;
	} rcst_memreq_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic dest;
		logic [31:0] data;
	} rcst_cmd_t;

	// ==========================================================
	// Whole state of the streamer
	typedef struct packed {
		logic [`RCST_FIFO_LINES-1:0][`RCST_LINE_BITS-1:0] fifo;
		logic [2:0] wr_ptr, rd_ptr;
		logic [4:0] count, outst;
		logic [3:0] dw_idx;
		logic en;
		logic [8:0] len_pg;
		logic [31:0] start, tail, ftail, head, fhead, pcur;
		logic el_pend, el_wait, el_has1;
		logic [31:0] el_addr, el_start1, el_tail1;
		rcst_pst_t pst;
		logic [8:0] rem;
		logic [9:0] cmd_len;
		logic dest, mode;
		rcst_cmd_t out;
		logic irq_user, irq_ctx, fl3d, flcmp, ack;
		logic [31:0] rdata;
	} rcst_state_t;

endpackage : rcst_pkg

// File: rcst_mem_model.sv
`timescale 1ns/100ps

// ==========================================================
// Memory partner: accepts line reads and answers them in order.
module rcst_mem_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire rcst_pkg::rcst_memreq_t req_i,
	output logic ready_o,
	output logic rsp_valid_o,
	output logic [511:0] rsp_data_o
);
	logic [31:0] dw [int unsigned];
	logic [31:0] pend [$];
	int unsigned dly;

	// Unwritten places read as zero, which the parser takes as a no-op.
	function automatic logic [31:0] rd(input logic [31:0] a);
		return dw.exists(a) ? dw[a] : 32'h0;
	endfunction : rd

	// Random stalls on accept and on return; between answers the data
	// bus shows the inverse of the last line, so stale data never passes.
	always @(posedge clk_i) begin
		if (rst_i) begin
			pend.delete();
			ready_o <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_data_o <= '0;
			dly = 0;
		end else begin
			if (req_i.valid && ready_o)
				pend.push_back(req_i.addr);
			ready_o <= ($urandom % 3) != 0;
			if (dly != 0)
				dly--;
			if (dly == 0 && pend.size() != 0) begin
				for (int i = 0; i < 16; i++)
					rsp_data_o[32*i +: 32] <= rd(pend[0] + 4*i);
				void'(pend.pop_front());
				rsp_valid_o <= 1'b1;
				dly = 1 + $urandom % 4;
			end else begin
				rsp_valid_o <= 1'b0;
				if (rsp_valid_o)
					rsp_data_o <= ~rsp_data_o;
			end
		end
	end
endmodule : rcst_mem_model

// File: rcst_streamer_tb.sv
`timescale 1ns/100ps
`include "rcst_defs.svh"

module rcst_streamer_tb;
	logic clk_i, sys_rst_i, clk_en_i, mem_req_ready_i, mem_rsp_valid_i;
	logic cmd_ready_i, hold, ak, mmio_ack_o, pipe_mode_o, ring_empty_o;
	logic user_irq_o, ctx_irq_o, flush_3d_o, flush_cmp_o;
	rcst_pkg::rcst_mmio_t mmio_i;
	rcst_pkg::rcst_memreq_t mem_req_o;
	rcst_pkg::rcst_cmd_t cmd_o;
	logic [511:0] mem_rsp_data_i;
	logic [31:0] mmio_rdata_o, q, wp;
	logic [32:0] exp_req [$];
	logic [33:0] exp_cmd [$];
	logic [15:0] wa [3] = '{16'h2830, 16'h1ffc, 16'h2800};
	int err_total, comparisons, reqs, n_user, n_ctx, n_flush;

	rcst_streamer rcst_streamer_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i), .mmio_i(mmio_i), .mmio_ack_o(mmio_ack_o),
		.mmio_rdata_o(mmio_rdata_o), .mem_req_o(mem_req_o),
		.mem_req_ready_i(mem_req_ready_i), .mem_rsp_valid_i(mem_rsp_valid_i),
		.mem_rsp_data_i(mem_rsp_data_i), .cmd_o(cmd_o),
		.cmd_ready_i(cmd_ready_i), .pipe_mode_o(pipe_mode_o),
		.ring_empty_o(ring_empty_o), .user_irq_o(user_irq_o),
		.ctx_irq_o(ctx_irq_o), .flush_3d_o(flush_3d_o),
		.flush_cmp_o(flush_cmp_o));
	rcst_mem_model rcst_mem_model_inst (.clk_i(clk_i), .rst_i(sys_rst_i),
		.req_i(mem_req_o), .ready_o(mem_req_ready_i),
		.rsp_valid_o(mem_rsp_valid_i), .rsp_data_o(mem_rsp_data_i));

	// ==========================================================
	// Reporting
	task chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	task print_verdict;
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	// ==========================================================
	// Stimulus helpers
	task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_i);
		mmio_i <= {1'b1, w, a, d};
		@(posedge clk_i);
		mmio_i.valid <= 1'b0;
		#1 ak = mmio_ack_o;
		q = mmio_rdata_o;
	endtask : acc

	task put(input logic [31:0] v);
		rcst_mem_model_inst.dw[wp] = v;
		wp += 4;
	endtask : put

	// Graphics command with nb body dwords; 3D and compute bodies are
	// expected at the front end without their header.
	task cmd(input logic [1:0] p, input logic [2:0] o, input logic [7:0] s,
		input int nb);
		logic [31:0] v;
		put({3'h3, p, o, s, 8'h00, 8'(nb - 1)});
		for (int i = 0; i < nb; i++) begin
			v = $urandom;
			put(v);
			if (p >= 2'h2)
				exp_cmd.push_back({i == nb - 1, p == 2'h2, v});
		end
	endtask : cmd

	// Bounded wait until all expected traffic is seen and the ring drains.
	task idle(input int n);
		int i;
		for (i = 0; i < n && !(ring_empty_o === 1'b1 && exp_cmd.size() == 0
			&& exp_req.size() == 0); i++)
			@(posedge clk_i);
		if (i == n) begin
			chk(1'b0, "wait ran out");
			print_verdict();
		end
	endtask : idle

	// ==========================================================
	// Clock and front end with random back-pressure.
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
		cmd_ready_i <= !hold && ($urandom % 4 != 0);

	// Every memory request and every forwarded dword is checked against
	// the queues built from the ring contents.
	always @(posedge clk_i) if (!sys_rst_i) begin
		if (mem_req_o.valid && mem_req_ready_i) begin
			reqs++;
			chk(exp_req.size() != 0 && {mem_req_o.el, mem_req_o.addr} === exp_req[0], "memory request");
			if (exp_req.size() != 0)
				void'(exp_req.pop_front());
		end
		if (cmd_o.valid && cmd_ready_i) begin
			chk(exp_cmd.size() != 0 && {cmd_o.last, cmd_o.dest, cmd_o.data} === exp_cmd[0], "command dword");
			if (exp_cmd.size() != 0)
				void'(exp_cmd.pop_front());
		end
		if (flush_3d_o || flush_cmp_o)
			chk(flush_3d_o === flush_cmp_o, "flush pulses apart");
		n_user += user_irq_o;
		n_ctx += ctx_irq_o;
		n_flush += flush_3d_o;
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h15275056));
		{err_total, comparisons, reqs, n_user, n_ctx, n_flush} = '0;
		mmio_i = '0;
		hold = 1'b1;
		clk_en_i = 1'b1;
		sys_rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		#1 chk(mem_req_o.valid === 1'b0 && cmd_o.valid === 1'b0 && mmio_ack_o === 1'b0, "reset outputs");
		// Only the own window is claimed; aliases must not land.
		acc(1'b1, `RCST_TAIL_OFS, 32'h340);
		for (int i = 0; i < 3; i++) begin
			acc(1'b1, wa[i], 32'h0);
			chk(ak === 1'b0, "foreign cycle claimed");
		end
		acc(1'b0, 16'h2100, 32'h0);
		chk(ak === 1'b1 && q === 32'h0, "unmapped read");
		acc(1'b0, `RCST_TAIL_OFS, 32'h0);
		chk(ak === 1'b1 && q === 32'h340, "tail readback");
		// Ring: one 12-line 3D command, then local and mixed commands.
		wp = 32'h10000;
		cmd(2'h3, 3'h0, 8'h08, 191);
		put(32'h0);
		put({3'h0, 6'h02, 23'h0});
		put({3'h0, 6'h04, 23'h0});
		cmd(2'h1, 3'h1, 8'h04, 2);
		cmd(2'h2, 3'h0, 8'h01, 1);
		cmd(2'h3, 3'h0, 8'h0a, 2);
		repeat (5) put(32'h0);
		for (int k = 0; k < 13; k++)
			exp_req.push_back({1'b0, 32'h10000 + 32'h40 * k});
		acc(1'b1, `RCST_START_OFS, 32'h10000);
		acc(1'b1, `RCST_HEAD_OFS, 32'h0);
		acc(1'b1, `RCST_CTL_OFS, 32'h1);
		// With the front end stalled, fetch fills exactly eight lines.
		repeat (150) @(posedge clk_i);
		#1 chk(reqs === 8, "fetch ahead of free slots");
		chk(cmd_o.valid === 1'b1 && ring_empty_o === 1'b0, "parser idle");
		acc(1'b0, `RCST_HEAD_OFS, 32'h0);
		chk(q === 32'h0, "head moved on fetch");
		// Freeze with memory quiet: outputs drop, state must survive.
		@(posedge clk_i);
		clk_en_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1 chk(cmd_o.valid === 1'b0 && mem_req_o.valid === 1'b0, "freeze");
		@(posedge clk_i);
		clk_en_i <= 1'b1;
		#1 chk(cmd_o.valid === 1'b1 && reqs === 8, "state lost");
		hold <= 1'b0;
		idle(4000);
		acc(1'b0, `RCST_HEAD_OFS, 32'h0);
		chk(q === 32'h340 && reqs === 13, "ring end");
		chk(n_user === 1 && n_flush === 1 && pipe_mode_o === 1'b1, "local");
		// Two-element execution list of no-op rings.
		rcst_mem_model_inst.dw[32'h20000] = 32'h30000;
		rcst_mem_model_inst.dw[32'h20004] = 32'h40;
		rcst_mem_model_inst.dw[32'h20008] = 32'h31000;
		rcst_mem_model_inst.dw[32'h2000c] = 32'h40;
		exp_req.push_back({1'b1, 32'h20000});
		exp_req.push_back({1'b0, 32'h30000});
		exp_req.push_back({1'b0, 32'h31000});
		acc(1'b1, `RCST_ELSP_OFS, 32'h20000);
		idle(4000);
		repeat (4) @(posedge clk_i);
		acc(1'b0, `RCST_HEAD_OFS, 32'h0);
		chk(q === 32'h40 && n_ctx === 1, "list elements");
		// Status: no element left, idle, compute mode, empty, enabled.
		acc(1'b0, `RCST_STAT_OFS, 32'h0);
		chk(q === 32'hf, "status word");
		print_verdict();
	end
endmodule : rcst_streamer_tb
